// ==== logic/rsfm_fault_merge.sv ====
// gates synchronised fault levels by their masks onto the fault line
`timescale 1ns/10ps

module rsfm_fault_merge
#(
  parameter int unsigned FAULT_N = rsfm_pkg::FAULT_N
)
(
  // clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_reset,
  // faults and masks, a set mask bit blocks its source
  input  wire logic [FAULT_N-1:0] i_fault,
  input  wire logic [FAULT_N-1:0] i_mask,
  // active low supply fault
  output logic                    o_supply_fault_n
);

  logic fault_n_q;
  wire  any_unmasked = |(i_fault & ~i_mask);

  // the line idles high so a reset never reports a false fault
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      fault_n_q <= 1'b1;
    else
      fault_n_q <= ~any_unmasked;
  end

  assign o_supply_fault_n = fault_n_q;

endmodule // rsfm_fault_merge

// ==== logic/rsfm_pkg.sv ====
// constants shared by the regulator sleep, fault mask and fuse registers
package rsfm_pkg;

  // ---------------------------------------------------------------
  // register map: byte address is four times the register index
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned REG_W         = 16;
  localparam logic [7:0]  IDX_REG4_LP   = 8'hd3;
  localparam logic [7:0]  IDX_FLT_MASK  = 8'hd7;
  localparam logic [7:0]  IDX_BG_FUSE   = 8'hd8;
  localparam logic [7:0]  IDX_OSC_FUSE  = 8'hd9;
  localparam logic [1:0]  IDX_SHIFT_PAD = 2'h0;

  // ---------------------------------------------------------------
  // reg4_low_power_config fields
  // ---------------------------------------------------------------
  localparam int unsigned ACTION_LSB    = 12;
  localparam int unsigned TRIGGER_LSB   = 8;
  localparam int unsigned VCODE_LSB     = 0;
  localparam logic [1:0]  ACTION_IMAGE  = 2'h0;
  localparam logic [1:0]  ACTION_OFF    = 2'h1;
  localparam logic [1:0]  ACTION_RST    = 2'h0;
  localparam logic [1:0]  TRIG_RST      = 2'h0;
  localparam logic [4:0]  VCODE_RST     = 5'h1c;

  typedef enum logic [1:0] {
    RSFM_TRIG_REG_BIT,
    RSFM_TRIG_PIN_ONE,
    RSFM_TRIG_PIN_TWO,
    RSFM_TRIG_PIN_THREE
  } rsfm_trigger_type;

  // ---------------------------------------------------------------
  // supply_fault_masks fields; fault vector is
  // {limit switch, reg4..reg1, buck6..buck1}
  // ---------------------------------------------------------------
  localparam int unsigned FAULT_N       = 11;
  localparam int unsigned LS_MASK_BIT   = 15;
  localparam int unsigned REG_MASK_LSB  = 8;
  localparam int unsigned BUCK_MASK_LSB = 0;
  localparam logic [15:0] MASK_RST      = 16'h0000;
  localparam logic [15:0] MASK_WMASK    = 16'h8f3f;

  // ---------------------------------------------------------------
  // fuse control registers
  // ---------------------------------------------------------------
  localparam int unsigned FUSE_BIT      = 15;
  localparam logic        FUSE_RST      = 1'b0;
  localparam int unsigned SYNC_STAGES   = 2;

endpackage : rsfm_pkg

// ==== logic/rsfm_regs.sv ====
// regulator sleep, supply fault mask and trim fuse register bank
//
// How it works
// - action 00 moves reg4 to its image voltage, 01 switches it off.
// - trigger 00 uses hibernate bit, 01..11 use low-power pins one..three.
// - five-bit image voltage code, 50mV then 100mV steps, resets to 11100.
// - action and trigger fields restore defaults on the state machine reset.
// - mask bit 15 gates the limit switch fault onto the fault line.
// - mask bits 11..8 gate faults of regulators four..one.
// - mask bits 5..0 gate faults of bucks six..one.
// - mask 0 passes, 1 blocks; all masks clear on state machine reset.
// - bandgap bit 15 powers the bandgap trim fuses while set.
// - the oscillator bit ignores writes while the key is locked.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps

module rsfm_regs
#(
  parameter int unsigned FAULT_N = rsfm_pkg::FAULT_N
)
(
  // clock and resets
  input  wire logic                         i_core_clk,
  input  wire logic                         i_reset,
  input  wire logic                         i_psm_reset,
  // wishbone slave
  input  wire logic                         i_wb_cyc,
  input  wire logic                         i_wb_stb,
  input  wire logic                         i_wb_we,
  input  wire logic [rsfm_pkg::ADDR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]                   i_wb_sel,
  input  wire logic [rsfm_pkg::DATA_W-1:0]  i_wb_dat,
  output logic      [rsfm_pkg::DATA_W-1:0]  o_wb_dat,
  output logic                              o_wb_ack,
  // sleep sources, the pins are asynchronous
  input  wire logic                         i_hibernate_bit,
  input  wire logic                         i_low_power_pin_one,
  input  wire logic                         i_low_power_pin_two,
  input  wire logic                         i_low_power_pin_three,
  // security key state, same clock
  input  wire logic                         i_key_unlocked,
  // asynchronous fault levels {limit switch, reg4..1, buck6..1}
  input  wire logic [FAULT_N-1:0]           i_fault,
  // regulator 4 sleep control
  output logic                              o_reg4_sleep,
  output logic                              o_reg4_sleep_off,
  output logic                              o_reg4_sleep_image,
  output logic      [4:0]                   o_reg4_sleep_voltage_code,
  // trim fuses
  output logic                              o_bandgap_fuse_current,
  output logic                              o_bandgap_trim_load,
  output logic                              o_oscillator_fuse_current,
  output logic                              o_oscillator_trim_load,
  // supply fault, active low
  output logic                              o_supply_fault_n
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [FAULT_N-1:0] mask_vector(
    input logic [15:0] r
  );
    mask_vector = {r[rsfm_pkg::LS_MASK_BIT],
                   r[rsfm_pkg::REG_MASK_LSB +: 4],
                   r[rsfm_pkg::BUCK_MASK_LSB +: 6]};
  endfunction

  // byte-lane merge of a 16-bit register under sel and a writable mask
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0]  sel,
    input logic [15:0] wmask
  );
    logic [15:0] lanes;
    lanes      = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
    lane_merge = (old_v & ~lanes) | (new_v & lanes);
  endfunction

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic                             ack_q;
  logic [rsfm_pkg::DATA_W-1:0]      rdat_q;
  wire  [7:0] idx      = i_wb_adr[rsfm_pkg::ADDR_W-1:2];
  wire        aligned  = i_wb_adr[1:0] == rsfm_pkg::IDX_SHIFT_PAD;
  wire        req      = i_wb_cyc && i_wb_stb && !ack_q;
  wire        wr       = req && i_wb_we;
  wire        hit_lp   = aligned && idx == rsfm_pkg::IDX_REG4_LP;
  wire        hit_mask = aligned && idx == rsfm_pkg::IDX_FLT_MASK;
  wire        hit_bg   = aligned && idx == rsfm_pkg::IDX_BG_FUSE;
  wire        hit_osc  = aligned && idx == rsfm_pkg::IDX_OSC_FUSE;
  wire [1:0]  sel16    = i_wb_sel[1:0];
  wire [15:0] wdat16   = i_wb_dat[15:0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [1:0]  action_q;
  logic [1:0]  trigger_q;
  logic [4:0]  vcode_q;
  logic [15:0] mask_q;
  logic        bg_fuse_q;
  logic        osc_fuse_q;

  wire [15:0] lp_view = {2'h0, action_q, 2'h0, trigger_q, 3'h0, vcode_q};
  wire [15:0] lp_wmask = 16'h331f;
  wire [15:0] lp_new  = lane_merge(lp_view, wdat16, sel16, lp_wmask);
  wire [15:0] mask_new =
    lane_merge(mask_q, wdat16, sel16, rsfm_pkg::MASK_WMASK);
  wire        fuse_lane = sel16[1];
  wire        bg_wr    = wr && hit_bg && fuse_lane;
  wire        osc_wr   = wr && hit_osc && fuse_lane && i_key_unlocked;

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || i_psm_reset)
    begin
      action_q  <= rsfm_pkg::ACTION_RST;
      trigger_q <= rsfm_pkg::TRIG_RST;
      mask_q    <= rsfm_pkg::MASK_RST;
    end
    else
    begin
      if (wr && hit_lp)
      begin
        action_q  <= lp_new[rsfm_pkg::ACTION_LSB +: 2];
        trigger_q <= lp_new[rsfm_pkg::TRIGGER_LSB +: 2];
      end
      if (wr && hit_mask)
        mask_q <= mask_new;
    end
  end

  // the voltage code and fuse bits follow only the plain reset
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      vcode_q    <= rsfm_pkg::VCODE_RST;
      bg_fuse_q  <= rsfm_pkg::FUSE_RST;
      osc_fuse_q <= rsfm_pkg::FUSE_RST;
    end
    else
    begin
      if (wr && hit_lp)
        vcode_q <= lp_new[rsfm_pkg::VCODE_LSB +: 5];
      if (bg_wr)
        bg_fuse_q <= wdat16[rsfm_pkg::FUSE_BIT];
      if (osc_wr)
        osc_fuse_q <= wdat16[rsfm_pkg::FUSE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // read data and acknowledge; unmapped addresses read zero
  // ---------------------------------------------------------------
  wire [15:0] rd16 =
    hit_lp   ? lp_view :
    hit_mask ? mask_q :
    hit_bg   ? {bg_fuse_q, 15'h0000} :
    hit_osc  ? {osc_fuse_q, 15'h0000} : 16'h0000;

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end
    else
    begin
      ack_q  <= req;
      rdat_q <= req ? {16'h0000, rd16} : '0;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ---------------------------------------------------------------
  // sleep selection
  // ---------------------------------------------------------------
  logic [2:0] pins_s;

  rsfm_sync #(.WIDTH(3)) u_pin_sync
  (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_async    ({i_low_power_pin_three, i_low_power_pin_two,
                  i_low_power_pin_one}),
    .o_sync     (pins_s)
  );

  rsfm_pkg::rsfm_trigger_type trig_e;
  logic sleep_sel;
  assign trig_e = rsfm_pkg::rsfm_trigger_type'(trigger_q);

  always_comb
  begin
    case (trig_e)
      rsfm_pkg::RSFM_TRIG_REG_BIT:   sleep_sel = i_hibernate_bit;
      rsfm_pkg::RSFM_TRIG_PIN_ONE:   sleep_sel = pins_s[0];
      rsfm_pkg::RSFM_TRIG_PIN_TWO:   sleep_sel = pins_s[1];
      rsfm_pkg::RSFM_TRIG_PIN_THREE: sleep_sel = pins_s[2];
      default:                       sleep_sel = 1'b0;
    endcase
  end

  // reserved action codes keep the regulator at its normal setting
  wire go_off   = sleep_sel && action_q == rsfm_pkg::ACTION_OFF;
  wire go_image = sleep_sel && action_q == rsfm_pkg::ACTION_IMAGE;

  logic sleep_q;
  logic off_q;
  logic image_q;
  logic [4:0] vout_q;

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      sleep_q <= 1'b0;
      off_q   <= 1'b0;
      image_q <= 1'b0;
      vout_q  <= rsfm_pkg::VCODE_RST;
    end
    else
    begin
      sleep_q <= sleep_sel;
      off_q   <= go_off;
      image_q <= go_image;
      vout_q  <= vcode_q;
    end
  end

  assign o_reg4_sleep              = sleep_q;
  assign o_reg4_sleep_off          = off_q;
  assign o_reg4_sleep_image        = image_q;
  assign o_reg4_sleep_voltage_code = vout_q;

  // ---------------------------------------------------------------
  // fuse current follows each bit while set, trim load pulses on its falling edge
  // ---------------------------------------------------------------
  logic bg_prev_q;
  logic osc_prev_q;
  logic bg_load_q;
  logic osc_load_q;
  logic bg_cur_q;
  logic osc_cur_q;

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      bg_prev_q  <= 1'b0;
      osc_prev_q <= 1'b0;
      bg_load_q  <= 1'b0;
      osc_load_q <= 1'b0;
      bg_cur_q   <= 1'b0;
      osc_cur_q  <= 1'b0;
    end
    else
    begin
      bg_prev_q  <= bg_fuse_q;
      osc_prev_q <= osc_fuse_q;
      bg_load_q  <= bg_prev_q && !bg_fuse_q;
      osc_load_q <= osc_prev_q && !osc_fuse_q;
      bg_cur_q   <= bg_fuse_q;
      osc_cur_q  <= osc_fuse_q;
    end
  end

  assign o_bandgap_fuse_current    = bg_cur_q;
  assign o_bandgap_trim_load       = bg_load_q;
  assign o_oscillator_fuse_current = osc_cur_q;
  assign o_oscillator_trim_load    = osc_load_q;

  // ---------------------------------------------------------------
  // supply fault line
  // ---------------------------------------------------------------
  logic [FAULT_N-1:0] fault_s;
  wire  [FAULT_N-1:0] mask_v = mask_vector(mask_q);

  rsfm_sync #(.WIDTH(FAULT_N)) u_fault_sync
  (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_async    (i_fault),
    .o_sync     (fault_s)
  );

  rsfm_fault_merge #(.FAULT_N(FAULT_N)) u_fault_merge
  (
    .i_core_clk       (i_core_clk),
    .i_reset          (i_reset),
    .i_fault          (fault_s),
    .i_mask           (mask_v),
    .o_supply_fault_n (o_supply_fault_n)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  wire [FAULT_N-1:0] live = i_fault & ~mask_v;

  sequence pin_one_held;
    (trigger_q == 2'h1 && i_low_power_pin_one)[*3];
  endsequence

  sequence osc_locked_write;
    wr && hit_osc && fuse_lane && !i_key_unlocked;
  endsequence

  bus_ack_a : assert property (req |=> ack_q ##1 !ack_q)
    else $error("ack not a single pulse after request");

  pin_trigger_a : assert property
    (pin_one_held |=> o_reg4_sleep)
    else $error("pin one did not put regulator 4 to sleep");

  sleep_off_a : assert property
    (o_reg4_sleep_off |-> !o_reg4_sleep_image &&
     $past(action_q) == rsfm_pkg::ACTION_OFF)
    else $error("sleep off without off action");

  vcode_reset_a : assert property
    (i_psm_reset && !(wr && hit_lp) ##1 !(wr && hit_lp)
     |=> o_reg4_sleep_voltage_code == $past(vcode_q, 2))
    else $error("voltage code changed by state machine reset");

  psm_restore_a : assert property
    (i_psm_reset |=> action_q == rsfm_pkg::ACTION_RST &&
     trigger_q == rsfm_pkg::TRIG_RST && mask_q == rsfm_pkg::MASK_RST)
    else $error("state machine reset did not restore defaults");

  fault_pass_a : assert property
    ((live != '0 && $stable(mask_v))[*4] |=> !o_supply_fault_n)
    else $error("unmasked fault did not reach fault line");

  fault_block_a : assert property
    ((live == '0 && $stable(mask_v))[*4] |=> o_supply_fault_n)
    else $error("masked fault reached fault line");

  osc_lock_a : assert property
    (osc_locked_write |=> $stable(osc_fuse_q))
    else $error("locked write changed oscillator fuse bit");

  bg_load_a : assert property
    ($fell(bg_fuse_q) |=> o_bandgap_trim_load ##1 !o_bandgap_trim_load)
    else $error("bandgap trim load pulse missing");

  bg_current_a : assert property
    (bg_fuse_q |=> o_bandgap_fuse_current)
    else $error("bandgap fuse current off while bit set");

endmodule // rsfm_regs

// ==== logic/rsfm_sync.sv ====
// two-flop synchroniser for a vector of independent levels
`timescale 1ns/10ps

module rsfm_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // meta_q is read only by sync_q
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // rsfm_sync

// ==== verification/tb_top.sv ====
// self-checking bench for the regulator sleep, fault mask and fuse registers
`timescale 1ns/10ps

`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [9:0] A_LP = {rsfm_pkg::IDX_REG4_LP, 2'b00};
  localparam logic [9:0] A_MK = {rsfm_pkg::IDX_FLT_MASK, 2'b00};
  localparam logic [9:0] A_BG = {rsfm_pkg::IDX_BG_FUSE, 2'b00};
  localparam logic [9:0] A_OS = {rsfm_pkg::IDX_OSC_FUSE, 2'b00};
  logic        i_core_clk, i_reset, i_psm_reset;
  logic        cyc, stb, we, ack, hib, p1, p2, p3, key;
  logic        slp, slp_off, slp_img, bg_cur, bg_ld, os_cur, os_ld;
  logic        flt_n;
  logic [9:0]  adr, a_r;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [10:0] fault;
  logic [4:0]  vcode;
  logic [15:0] m_lp, m_mask, m_bg, m_os;
  integer      n_errors, n_compared, seed, bg_pl, os_pl, i, t, ac, r;

  rsfm_regs #(.FAULT_N(11)) u_rsfm_regs (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_psm_reset(i_psm_reset),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_hibernate_bit(hib), .i_low_power_pin_one(p1),
    .i_low_power_pin_two(p2), .i_low_power_pin_three(p3),
    .i_key_unlocked(key), .i_fault(fault), .o_reg4_sleep(slp),
    .o_reg4_sleep_off(slp_off), .o_reg4_sleep_image(slp_img),
    .o_reg4_sleep_voltage_code(vcode), .o_bandgap_fuse_current(bg_cur),
    .o_bandgap_trim_load(bg_ld), .o_oscillator_fuse_current(os_cur),
    .o_oscillator_trim_load(os_ld), .o_supply_fault_n(flt_n));

  initial
  begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // trim load pulses are counted so a missing or doubled pulse shows
  always @(posedge i_core_clk)
  begin
    if (!i_reset)
    begin
      bg_pl <= bg_pl + bg_ld;
      os_pl <= os_pl + os_ld;
    end
  end

  // ---------------------------------------------------------------
  // model and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [15:0] lanes(input logic [15:0] o, d,
                                        input logic [3:0] s,
                                        input logic [15:0] wm);
    logic [15:0] be;
    be = {{8{s[1]}}, {8{s[0]}}} & wm;
    return (o & ~be) | (d & be);
  endfunction

  function automatic logic [15:0] mread(input logic [9:0] a);
    case (a)
      A_LP:    return m_lp;
      A_MK:    return m_mask;
      A_BG:    return m_bg;
      A_OS:    return m_os;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic wb(input logic w, input logic [9:0] a,
                    input logic [15:0] d, input logic [3:0] s);
    @(posedge i_core_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {16'h0000, d};
    // no local limit: a slave that never answers is caught by the watchdog
    do
    begin
      @(posedge i_core_clk);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d,
                    input logic [3:0] s);
    wb(1'b1, a, d, s);
    case (a)
      A_LP: m_lp = lanes(m_lp, d, s, 16'h331f);
      A_MK: m_mask = lanes(m_mask, d, s, rsfm_pkg::MASK_WMASK);
      A_BG: m_bg = lanes(m_bg, d, s, 16'h8000);
      A_OS: m_os = key ? lanes(m_os, d, s, 16'h8000) : m_os;
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [9:0] a);
    wb(1'b0, a, 16'h0000, 4'hf);
    `CHK(q, {16'h0000, mread(a)})
  endtask

  task automatic step(input integer n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic chk_fault();
    logic [10:0] em;
    em = {m_mask[15], m_mask[11:8], m_mask[5:0]};
    step(5);
    `CHK(flt_n, ~|(fault & ~em))
  endtask

  task automatic fuse(input logic [9:0] a, input logic kv);
    integer      p0;
    logic        was;
    logic [15:0] mv;
    @(posedge i_core_clk);
    key <= kv;
    wr(a, 16'h8000, 4'h3);
    step(2);
    mv = mread(a);
    was = mv[15];
    `CHK((a == A_BG) ? bg_cur : os_cur, was)
    rd_chk(a);
    p0 = (a == A_BG) ? bg_pl : os_pl;
    wr(a, 16'h0000, 4'h3);
    step(5);
    `CHK(((a == A_BG) ? bg_pl : os_pl) - p0, was)
  endtask

  task automatic tally_and_finish();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #(25 * 20000);
    n_errors++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {i_reset, i_psm_reset, cyc, stb, we, hib, p1, p2, p3} = 9'h100;
    {adr, sel, wdat, fault} = '0;
    key = 1'b1;
    n_errors = 0;
    n_compared = 0;
    seed = 41;
    bg_pl = 0;
    os_pl = 0;
    m_lp = 16'h001c;
    {m_mask, m_bg, m_os} = '0;
    repeat (10) @(posedge i_core_clk);
    i_reset <= 1'b0;
    step(1);
    `CHK(vcode, 5'h1c)
    `CHK(flt_n, 1'b1)
    rd_chk(A_LP);
    rd_chk(A_MK);
    // random lanes and data, including reserved bits and stray addresses
    for (i = 0; i < 24; i++)
    begin
      r = $random(seed);
      @(posedge i_core_clk);
      key <= r[20];
      // the address is picked in a bench variable; the bus task drives adr
      case (i % 6)
        0: a_r = A_LP;
        1: a_r = A_MK;
        2: a_r = A_BG;
        3: a_r = A_OS;
        4: a_r = 10'h350;
        default: a_r = 10'h34d;
      endcase
      wr(a_r, r[15:0], r[19:16]);
      rd_chk(a_r);
    end
    // every trigger source against every action code
    for (t = 0; t < 4; t++)
      for (ac = 0; ac < 4; ac++)
      begin
        r = $random(seed);
        wr(A_LP, {2'b00, 2'(ac), 2'b00, 2'(t), 3'b000, r[4:0]}, 4'h3);
        @(posedge i_core_clk);
        {p3, p2, p1, hib} <= r[8:5];
        step(5);
        `CHK(slp, r[5 + t])
        `CHK(slp_off, r[5 + t] && ac == 1)
        `CHK(slp_img, r[5 + t] && ac == 0)
        `CHK(vcode, m_lp[4:0])
      end
    // one source at a time, its own mask bit cleared then alone set
    for (i = 0; i < 22; i++)
    begin
      t = i % 11;
      t = (t < 6) ? t : (t < 10) ? t + 2 : 15;
      wr(A_MK, (i < 11) ? ~(16'h1 << t) : (16'h1 << t), 4'h3);
      @(posedge i_core_clk);
      fault <= 11'h1 << (i % 11);
      chk_fault();
    end
    for (i = 0; i < 16; i++)
    begin
      r = $random(seed);
      wr(A_MK, r[15:0], 4'h3);
      @(posedge i_core_clk);
      fault <= r[26:16] & {11{r[27]}};
      chk_fault();
    end
    // fuse bits: lane 1 needed, oscillator bit behind the key
    wr(A_BG, 16'h8000, 4'h1);
    rd_chk(A_BG);
    fuse(A_BG, 1'b0);
    fuse(A_OS, 1'b1);
    fuse(A_OS, 1'b0);
    // state machine reset clears action, trigger and masks only
    wr(A_LP, 16'h3312, 4'h3);
    wr(A_MK, 16'h8f3f, 4'h3);
    @(posedge i_core_clk);
    i_psm_reset <= 1'b1;
    @(posedge i_core_clk);
    i_psm_reset <= 1'b0;
    m_lp = m_lp & 16'h001f;
    m_mask = 16'h0000;
    rd_chk(A_LP);
    rd_chk(A_MK);
    step(2);
    `CHK(vcode, 5'h12)
    tally_and_finish();
  end
endmodule // tb_top
